// *** verilog/snr_defines.svh ***
// Register offsets, field positions, reset values and link constants for the readout slice
`ifndef SNR_DEFINES_SVH
`define SNR_DEFINES_SVH
`define SNR_OFS_RUN 8'h21
`define SNR_OFS_GO 8'h22
`define SNR_OFS_HALT 8'h23
`define SNR_OFS_ACT 8'h24
`define SNR_OFS_TEMP 8'h30
`define SNR_OFS_HUM 8'h33
`define SNR_BIT_TEMP 0
`define SNR_BIT_HUM 1
`define SNR_RES_CRC_MSB 23
`define SNR_RES_CRC_LSB 17
`define SNR_RES_VALID 16
`define SNR_RUN_RST 2'h0
`define SNR_ACT_RST 2'h0
`define SNR_RES_RST 24'h00_0000
`define SNR_CRC_POLY 7'h09
`define SNR_CRC_INIT 7'h7F
// Arbitrary target address on the two-wire link
`define SNR_LINK_ADDR 7'h2A
`define SNR_LINK_BITS 4'h8
`endif

// *** verilog/snr_pkg.sv ***
// Shared types for the sensor readout slice
package snr_pkg;
  typedef logic [15:0] snr_sample_t;
  typedef logic [23:0] snr_result_t;
  typedef logic [7:0] snr_byte_t;
  typedef enum logic [2:0] {
    LK_IDLE,
    LK_ADDR,
    LK_ADDR_ACK,
    LK_WRITE,
    LK_WRITE_ACK,
    LK_READ,
    LK_READ_ACK
  } snr_link_e;
endpackage

// *** verilog/snr_reg_if.sv ***
// Byte-wide register access carrier between the link target and the register slice
`timescale 1ns/100ps
interface snr_reg_if;
  import snr_pkg::*;
  snr_byte_t addr;
  snr_byte_t wrData;
  logic wrStrobe;
  logic rdStrobe;
  snr_byte_t rdData;
  modport target (output addr, output wrData, output wrStrobe, output rdStrobe, input rdData);
  modport regs (input addr, input wrData, input wrStrobe, input rdStrobe, output rdData);
endinterface

// *** verilog/snr_i2c_target.sv ***
// Two-wire target: address match, register pointer, auto-incrementing byte access
`timescale 1ns/100ps
`include "snr_defines.svh"
module snr_i2c_target
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Two-wire pins
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeB,
  // Register side
  snr_reg_if.target bus
);
  import snr_pkg::*;

  logic [2:0] sclSync_reg;
  logic [2:0] sdaSync_reg;
  snr_link_e state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  snr_byte_t shift_reg, shift_next;
  snr_byte_t ptr_reg, ptr_next;
  snr_byte_t wrData_reg, wrData_next;
  logic rw_reg, rw_next;
  logic first_reg, first_next;
  logic acked_reg, acked_next;
  logic oeB_reg, oeB_next;
  logic wrStb_reg, wrStb_next;
  logic sdaOut_reg;

  // Edge decode uses only the second and third stages, never the first
  wire sclRise = sclSync_reg[1] & ~sclSync_reg[2];
  wire sclFall = ~sclSync_reg[1] & sclSync_reg[2];
  wire sclHigh = sclSync_reg[1] & sclSync_reg[2];
  wire sdaBit = sdaSync_reg[1];
  wire startSeen = sclHigh & ~sdaSync_reg[1] & sdaSync_reg[2];
  wire stopSeen = sclHigh & sdaSync_reg[1] & ~sdaSync_reg[2];
  wire loadByte = sclFall & ~startSeen & ~stopSeen
    & (((state_reg == LK_ADDR_ACK) & rw_reg) | ((state_reg == LK_READ_ACK) & acked_reg));

  // Register side
  assign bus.addr = ptr_reg;
  assign bus.wrData = wrData_reg;
  assign bus.wrStrobe = wrStb_reg;
  assign bus.rdStrobe = loadByte;
  assign sdaOeB = oeB_reg;
  assign sdaOut = sdaOut_reg;

  // Bit-level sequencing; the pin only ever pulls low, so data changes on falling SCL
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    ptr_next = wrStb_reg ? ptr_reg + 8'h01 : ptr_reg;
    wrData_next = wrData_reg;
    rw_next = rw_reg;
    first_next = first_reg;
    acked_next = acked_reg;
    oeB_next = oeB_reg;
    wrStb_next = 1'b0;
    if (startSeen)
    begin
      state_next = LK_ADDR;
      cnt_next = 4'h0;
      oeB_next = 1'b1;
      first_next = 1'b1;
    end
    else if (stopSeen)
    begin
      state_next = LK_IDLE;
      oeB_next = 1'b1;
    end
    else if (loadByte)
    begin
      state_next = LK_READ;
      shift_next = bus.rdData;
      oeB_next = bus.rdData[7];
      cnt_next = 4'h1;
    end
    else
      case (state_reg)
        LK_ADDR, LK_WRITE:
          if (sclRise)
          begin
            shift_next = {shift_reg[6:0], sdaBit};
            cnt_next = cnt_reg + 4'h1;
          end
          else if (sclFall && cnt_reg == `SNR_LINK_BITS)
          begin
            oeB_next = 1'b0;
            if (state_reg == LK_ADDR)
            begin
              rw_next = shift_reg[0];
              state_next = LK_ADDR_ACK;
              if (shift_reg[7:1] != `SNR_LINK_ADDR)
              begin
                oeB_next = 1'b1;
                state_next = LK_IDLE;
              end
            end
            else
            begin
              state_next = LK_WRITE_ACK;
              first_next = 1'b0;
              if (first_reg)
                ptr_next = shift_reg;
              else
              begin
                wrStb_next = 1'b1;
                wrData_next = shift_reg;
              end
            end
          end
        LK_ADDR_ACK, LK_WRITE_ACK:
          if (sclFall)
          begin
            oeB_next = 1'b1;
            cnt_next = 4'h0;
            state_next = LK_WRITE;
          end
        LK_READ:
          if (sclFall)
          begin
            cnt_next = cnt_reg + 4'h1;
            shift_next = {shift_reg[6:0], 1'b0};
            oeB_next = shift_reg[6];
            if (cnt_reg == `SNR_LINK_BITS)
            begin
              oeB_next = 1'b1;
              ptr_next = ptr_reg + 8'h01;
              state_next = LK_READ_ACK;
            end
          end
        LK_READ_ACK:
          if (sclRise)
            acked_next = ~sdaBit;
          else if (sclFall)
            state_next = LK_IDLE;
        default:
          state_next = LK_IDLE;
      endcase
  end

  // Pin synchronisers and sequencing state
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sclSync_reg <= 3'h7;
      sdaSync_reg <= 3'h7;
      state_reg <= LK_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      wrData_reg <= 8'h00;
      rw_reg <= 1'b0;
      first_reg <= 1'b1;
      acked_reg <= 1'b0;
      oeB_reg <= 1'b1;
      wrStb_reg <= 1'b0;
      sdaOut_reg <= 1'b0;
    end
    else
    begin
      sclSync_reg <= {sclSync_reg[1:0], scl};
      sdaSync_reg <= {sdaSync_reg[1:0], sdaIn};
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      ptr_reg <= ptr_next;
      wrData_reg <= wrData_next;
      rw_reg <= rw_next;
      first_reg <= first_next;
      acked_reg <= acked_next;
      oeB_reg <= oeB_next;
      wrStb_reg <= wrStb_next;
      sdaOut_reg <= 1'b0;
    end
  end
endmodule

// *** verilog/snr_readout.sv ***
// Measurement control, activity status and double-buffered result readouts
`timescale 1ns/100ps
`include "snr_defines.svh"
// Notes on behaviour
// [RL1] Writing one to halt bit 1 ends continuous humidity measurement.
// [RL2] Writing one to halt bit 0 ends continuous temperature measurement.
// [RL3] A zero in a halt bit leaves that sensor running.
// [RL4] Activity bit 1 shows humidity measuring; zero when idle and after reset.
// [RL5] Activity bit 0 shows temperature measuring, zero when idle.
// [RL6] Temperature readout holds the latest completed temperature result.
// [RL7] Humidity readout holds the latest completed humidity result.
// [RL8] Temperature readout bits 23:17 carry CRC over data and valid bit.
// [RL9] Temperature valid bit set only for a real result.
// [RL10] Temperature data is little-endian 16-bit count of 1/64 kelvin.
// [RL11] Humidity readout bits 23:17 carry CRC over data and valid bit.
// [RL12] Humidity valid bit set only for a real result.
// [RL13] Humidity data is little-endian 16-bit count of 1/512 percent.
// [RL14] Reading a readout's first byte freezes all three bytes for the rest.
// [RL15] Run-mode bit per sensor: zero single shot, one continuous.
// [RL16] Writing one to a go bit starts that sensor measuring.
// [RL17] On completion update readout with valid set; single shot goes idle.
// [RL18] Host reads all three bytes from the first and checks valid and CRC.
module snr_readout
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Two-wire host pins
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeB,
  // Temperature front end
  output logic tempStart,
  input wire logic tempDone,
  input wire snr_pkg::snr_sample_t tempData,
  // Humidity front end
  output logic humStart,
  input wire logic humDone,
  input wire snr_pkg::snr_sample_t humData
);
  import snr_pkg::*;

  // CRC-7 over the valid bit and data field, valid bit first
  function automatic logic [6:0] crc7(input logic valid, input snr_sample_t data);
    logic [16:0] msg;
    logic [6:0] crc;
    logic fb;
    msg = {valid, data};
    crc = `SNR_CRC_INIT;
    for (int i = 16; i >= 0; i--)
    begin
      fb = crc[6] ^ msg[i];
      crc = {crc[5:0], 1'b0};
      if (fb)
        crc = crc ^ `SNR_CRC_POLY;
    end
    return crc;
  endfunction

  // Byte lane of a three-byte readout, lowest byte at the lowest offset
  function automatic snr_byte_t pickByte(input snr_result_t res, input logic [1:0] lane);
    case (lane)
      2'h0: return res[7:0];
      2'h1: return res[15:8];
      2'h2: return res[23:16];
      default: return 8'h00;
    endcase
  endfunction

  snr_reg_if bus ();

  logic [1:0] run_reg, run_next;
  logic [1:0] active_reg, active_next;
  logic [1:0] start_reg, start_next;
  snr_result_t live_reg [0:1];
  snr_result_t live_next [0:1];
  snr_result_t hold_reg [0:1];
  snr_result_t hold_next [0:1];
  snr_sample_t sample [0:1];

  // Link target drives the pins and the byte access carrier
  snr_i2c_target u_link
  (
    .clk(clk),
    .rst_b(rst_b),
    .scl(scl),
    .sdaIn(sdaIn),
    .sdaOut(sdaOut),
    .sdaOeB(sdaOeB),
    .bus(bus.target)
  );

  // Write decode; reserved bits of every write are ignored
  wire runWr = bus.wrStrobe && bus.addr == `SNR_OFS_RUN;
  wire goWr = bus.wrStrobe && bus.addr == `SNR_OFS_GO;
  wire haltWr = bus.wrStrobe && bus.addr == `SNR_OFS_HALT;
  wire [1:0] goBits = goWr ? bus.wrData[1:0] : 2'h0;
  wire [1:0] haltBits = haltWr ? bus.wrData[1:0] : 2'h0;

  // Completions count only while that sensor is marked measuring
  wire [1:0] doneVec = {humDone, tempDone};
  wire [1:0] doneAcc = doneVec & active_reg;
  assign sample[`SNR_BIT_TEMP] = tempData;
  assign sample[`SNR_BIT_HUM] = humData;

  // Per-sensor control; halt and go live at different offsets so they never collide
  assign run_next = runWr ? bus.wrData[1:0] : run_reg; // RL15
  assign active_next = (active_reg & ~haltBits & ~(doneAcc & ~run_reg)) | goBits; // RL1 RL2 RL3 RL16 RL17
  assign start_next = goBits | (doneAcc & run_reg & ~haltBits); // RL15 RL16

  // Readout first-byte access and result update per sensor
  wire [1:0] firstRead;
  assign firstRead[`SNR_BIT_TEMP] = bus.rdStrobe && bus.addr == `SNR_OFS_TEMP;
  assign firstRead[`SNR_BIT_HUM] = bus.rdStrobe && bus.addr == `SNR_OFS_HUM;
  generate
    for (genvar s = 0; s < 2; s++)
    begin : g_sensor
      // Fresh result carries valid set and its own CRC
      assign live_next[s] = doneAcc[s] ? {crc7(1'b1, sample[s]), 1'b1, sample[s]}
                                       : live_reg[s]; // RL6 RL7 RL8 RL9 RL11 RL12 RL17
      // Frozen copy so a completion mid-read cannot tear the three bytes
      assign hold_next[s] = firstRead[s] ? live_reg[s] : hold_reg[s]; // RL14
    end
  endgenerate

  // Read selection; first byte comes live since the copy is taken in the same cycle
  wire [7:0] tempOfs1 = `SNR_OFS_TEMP + 8'h01;
  wire [7:0] tempOfs2 = `SNR_OFS_TEMP + 8'h02;
  wire [7:0] humOfs1 = `SNR_OFS_HUM + 8'h01;
  wire [7:0] humOfs2 = `SNR_OFS_HUM + 8'h02;
  assign bus.rdData =
    (bus.addr == `SNR_OFS_RUN) ? {6'h00, run_reg} :
    (bus.addr == `SNR_OFS_ACT) ? {6'h00, active_reg} : // RL4 RL5
    (bus.addr == `SNR_OFS_TEMP) ? pickByte(live_reg[`SNR_BIT_TEMP], 2'h0) : // RL10
    (bus.addr == tempOfs1) ? pickByte(hold_reg[`SNR_BIT_TEMP], 2'h1) : // RL14
    (bus.addr == tempOfs2) ? pickByte(hold_reg[`SNR_BIT_TEMP], 2'h2) :
    (bus.addr == `SNR_OFS_HUM) ? pickByte(live_reg[`SNR_BIT_HUM], 2'h0) : // RL13
    (bus.addr == humOfs1) ? pickByte(hold_reg[`SNR_BIT_HUM], 2'h1) :
    (bus.addr == humOfs2) ? pickByte(hold_reg[`SNR_BIT_HUM], 2'h2) :
    8'h00;

  // Front-end start pulses leave straight from flops
  assign tempStart = start_reg[`SNR_BIT_TEMP];
  assign humStart = start_reg[`SNR_BIT_HUM];

  // Control and status flops
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      run_reg <= `SNR_RUN_RST;
      active_reg <= `SNR_ACT_RST;
      start_reg <= 2'h0;
    end
    else
    begin
      run_reg <= run_next;
      active_reg <= active_next;
      start_reg <= start_next;
    end
  end

  // Readout and holding copies, indexed by sensor
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < 2; i++)
      begin
        live_reg[i] <= `SNR_RES_RST;
        hold_reg[i] <= `SNR_RES_RST;
      end
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        live_reg[i] <= live_next[i];
        hold_reg[i] <= hold_next[i];
      end
    end
  end

  // Checks on the control, status and readout behaviour
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_temp_first;
    bus.rdStrobe && bus.addr == `SNR_OFS_TEMP;
  endsequence

  sequence s_hum_first;
    bus.rdStrobe && bus.addr == `SNR_OFS_HUM;
  endsequence

  sequence s_single_done(int s);
    doneAcc[s] && !run_reg[s] && !goBits[s];
  endsequence

  a_halt_hum_ends: assert property ( // RL1
    haltBits[1] |=> !active_reg[1] && !humStart)
    else $error("humidity still measuring after halt");

  a_halt_temp_ends: assert property ( // RL2
    haltBits[0] |=> !active_reg[0] && !tempStart)
    else $error("temperature still measuring after halt");

  a_halt_zero_keeps: assert property ( // RL3
    haltWr && !bus.wrData[1] && active_reg[1] && !doneAcc[1] |=> active_reg[1])
    else $error("zero halt bit stopped humidity");

  a_status_hum_read: assert property ( // RL4
    bus.rdStrobe && bus.addr == `SNR_OFS_ACT |-> bus.rdData[7:1] == {6'h00, active_reg[1]})
    else $error("activity read disagrees for humidity");

  a_status_temp_read: assert property ( // RL5
    bus.rdStrobe && bus.addr == `SNR_OFS_ACT |-> bus.rdData[0] == active_reg[0])
    else $error("activity read disagrees for temperature");

  a_temp_result_update: assert property ( // RL6
    doneAcc[0] |=> live_reg[0][15:0] == $past(tempData) && live_reg[0][`SNR_RES_VALID])
    else $error("temperature readout not updated on completion");

  a_hum_result_update: assert property ( // RL7
    doneAcc[1] |=> live_reg[1][15:0] == $past(humData) && live_reg[1][`SNR_RES_VALID])
    else $error("humidity readout not updated on completion");

  a_temp_crc_field: assert property ( // RL8
    live_reg[0][`SNR_RES_VALID] |->
      live_reg[0][23:17] == crc7(1'b1, live_reg[0][15:0]))
    else $error("temperature CRC field wrong");

  a_temp_valid_cause: assert property ( // RL9
    $rose(live_reg[0][`SNR_RES_VALID]) |-> $past(doneAcc[0]))
    else $error("temperature valid set without completion");

  a_temp_low_first: assert property ( // RL10
    s_temp_first |-> bus.rdData == live_reg[0][7:0])
    else $error("temperature low byte not at first offset");

  a_hum_crc_field: assert property ( // RL11
    live_reg[1][`SNR_RES_VALID] |->
      live_reg[1][23:17] == crc7(1'b1, live_reg[1][15:0]))
    else $error("humidity CRC field wrong");

  a_hum_valid_cause: assert property ( // RL12
    $rose(live_reg[1][`SNR_RES_VALID]) |-> $past(doneAcc[1]))
    else $error("humidity valid set without completion");

  a_hum_low_first: assert property ( // RL13
    s_hum_first |-> bus.rdData == live_reg[1][7:0])
    else $error("humidity low byte not at first offset");

  a_temp_hold_copy: assert property ( // RL14
    s_temp_first |=> hold_reg[0] == $past(live_reg[0]))
    else $error("temperature copy not taken on first byte");

  a_hum_hold_served: assert property ( // RL14
    bus.rdStrobe && bus.addr == humOfs2 |-> bus.rdData == hold_reg[1][23:16])
    else $error("humidity upper byte not from frozen copy");

  a_hum_hold_still: assert property ( // RL14
    !firstRead[1] |=> hold_reg[1] == $past(hold_reg[1]))
    else $error("humidity copy changed without first byte access");

  a_cont_restart: assert property ( // RL15
    doneAcc[1] && run_reg[1] && !haltBits[1] |=> active_reg[1] && humStart ##1 !humStart)
    else $error("continuous humidity did not restart");

  a_go_starts: assert property ( // RL16
    goBits[0] |=> active_reg[0] && tempStart)
    else $error("go did not start temperature");

  a_single_idle: assert property ( // RL17
    s_single_done(0) |=> !active_reg[0] && !tempStart)
    else $error("single shot temperature stayed active");
endmodule

// *** sim/snr_host_model.sv ***
// Two-wire host model that reaches the readout registers
`timescale 1ns/100ps
`include "snr_defines.svh"
module snr_host_model
(
  // Clock
  input wire logic clk,
  // Two-wire pins, data line released high by the pull-up
  output logic scl,
  output logic sdaPullB,
  input wire logic sdaLine
);
  // Bus idles released; the clock stands still between frames
  initial
  begin
    scl = 1'b1;
    sdaPullB = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Data moves two cycles after the clock falls, so no false start or stop
  task automatic txBit(input logic b);
    sdaPullB <= b;
    wt(8);
    scl <= 1'b1;
    wt(10);
    scl <= 1'b0;
    wt(2);
  endtask
  task automatic rxBit(output logic b);
    sdaPullB <= 1'b1;
    wt(8);
    scl <= 1'b1;
    wt(5);
    b = sdaLine;
    wt(5);
    scl <= 1'b0;
    wt(2);
  endtask
  // Serves both a first and a repeated start
  task automatic sendStart();
    sdaPullB <= 1'b1;
    wt(8);
    scl <= 1'b1;
    wt(10);
    sdaPullB <= 1'b0;
    wt(10);
    scl <= 1'b0;
    wt(2);
  endtask
  task automatic sendStop();
    sdaPullB <= 1'b0;
    wt(8);
    scl <= 1'b1;
    wt(10);
    sdaPullB <= 1'b1;
    wt(10);
  endtask
  // Byte out, then the target's answer; high means not acknowledged
  task automatic xfer(input logic [7:0] b, output logic nak);
    for (int i = 7; i >= 0; i--)
      txBit(b[i]);
    rxBit(nak);
  endtask
  task automatic rxByte(input logic last, output logic [7:0] b);
    logic x;
    for (int i = 7; i >= 0; i--)
    begin
      rxBit(x);
      b[i] = x;
    end
    txBit(last);
  endtask
  task automatic regWrite(input logic [7:0] ptr, input logic [7:0] data, output logic nak);
    logic n0;
    logic n1;
    logic n2;
    sendStart();
    xfer({`SNR_LINK_ADDR, 1'b0}, n0);
    xfer(ptr, n1);
    xfer(data, n2);
    sendStop();
    nak = n0 | n1 | n2;
  endtask
  // Bytes land little endian in val; last byte gets no acknowledge
  task automatic regRead(input logic [7:0] ptr, input int n, output logic [23:0] val,
                         output logic nak);
    logic n0;
    logic n1;
    logic n2;
    logic [7:0] b;
    val = 24'h00_0000;
    sendStart();
    xfer({`SNR_LINK_ADDR, 1'b0}, n0);
    xfer(ptr, n1);
    sendStart();
    xfer({`SNR_LINK_ADDR, 1'b1}, n2);
    for (int k = 0; k < n; k++)
    begin
      rxByte(k == n - 1, b);
      val[8 * k +: 8] = b;
    end
    sendStop();
    nak = n0 | n1 | n2;
  endtask
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench for the sensor readout slice
`timescale 1ns/100ps
`include "snr_defines.svh"
module tb_top;
  import snr_pkg::*;
  logic clk;
  logic rst_b;
  logic tempDone;
  logic humDone;
  snr_sample_t tempData;
  snr_sample_t humData;
  logic tempStart;
  logic humStart;
  logic scl;
  logic sdaPullB;
  logic sdaOut;
  logic sdaOeB;
  wire sdaLine;
  int n_errors;
  int cmp_count;
  int startCnt [2];
  // Open-drain line with pull-up: low when either party pulls
  assign sdaLine = sdaPullB & (sdaOeB | sdaOut);
  snr_readout uut (.clk(clk), .rst_b(rst_b), .scl(scl), .sdaIn(sdaLine), .sdaOut(sdaOut),
    .sdaOeB(sdaOeB), .tempStart(tempStart), .tempDone(tempDone), .tempData(tempData),
    .humStart(humStart), .humDone(humDone), .humData(humData));
  snr_host_model host (.clk(clk), .scl(scl), .sdaPullB(sdaPullB), .sdaLine(sdaLine));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Start pulses counted as the front end would see them
  always @(posedge clk)
  begin
    if (tempStart === 1'b1) startCnt[0]++;
    if (humStart === 1'b1) startCnt[1]++;
  end
  task automatic chk(input snr_result_t got, input snr_result_t exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input snr_byte_t ptr, input snr_byte_t data);
    logic nak;
    host.regWrite(ptr, data, nak);
    chk({23'h00_0000, nak}, 24'h00_0000, "write not acknowledged");
  endtask
  task automatic rdChk(input snr_byte_t ptr, input int n, input snr_result_t exp,
                       input string what);
    snr_result_t got;
    logic nak;
    host.regRead(ptr, n, got, nak);
    chk({23'h00_0000, nak}, 24'h00_0000, "read not acknowledged");
    chk(got, exp, what);
  endtask
  // Front end completion: one-cycle done with its sample
  task automatic feDone(input int s, input snr_sample_t d);
    @(posedge clk);
    tempDone <= (s == 0);
    humDone <= (s == 1);
    tempData <= d;
    humData <= d;
    @(posedge clk);
    tempDone <= 1'b0;
    humDone <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // CRC-7, polynomial 0x09, preset all ones, MSB first over valid and data
  function automatic snr_result_t expRes(input snr_sample_t d);
    logic [6:0] c;
    logic [16:0] m;
    c = `SNR_CRC_INIT;
    m = {1'b1, d};
    for (int i = 16; i >= 0; i--)
      c = {c[5:0], 1'b0} ^ ((c[6] ^ m[i]) ? `SNR_CRC_POLY : 7'h00);
    return {c, 1'b1, d};
  endfunction
  task automatic t_reset();
    logic nak;
    rdChk(`SNR_OFS_ACT, 1, 24'h00_0000, "activity after reset");
    rdChk(`SNR_OFS_TEMP, 3, 24'h00_0000, "temperature readout after reset");
    rdChk(`SNR_OFS_HUM, 3, 24'h00_0000, "humidity readout after reset");
    rdChk(`SNR_OFS_RUN, 1, 24'h00_0000, "run mode after reset");
    wr(`SNR_OFS_ACT, 8'hFF);
    rdChk(`SNR_OFS_ACT, 1, 24'h00_0000, "activity is read only");
    host.sendStart();
    host.xfer(8'h56, nak);
    host.sendStop();
    chk({23'h00_0000, nak}, 24'h00_0001, "foreign address acknowledged");
  endtask
  task automatic t_single();
    snr_sample_t d [2] = '{16'h12F4, 16'hA5C3};
    snr_byte_t ofs [2] = '{`SNR_OFS_TEMP, `SNR_OFS_HUM};
    int c0;
    for (int s = 0; s < 2; s++)
    begin
      c0 = startCnt[s];
      wr(`SNR_OFS_GO, 8'h01 << s);
      chk(24'(startCnt[s] - c0), 24'h00_0001, "one start pulse");
      rdChk(`SNR_OFS_ACT, 1, 24'h00_0001 << s, "activity while measuring");
      feDone(s, d[s]);
      rdChk(ofs[s], 3, expRes(d[s]), "result");
      rdChk(`SNR_OFS_ACT, 1, 24'h00_0000, "idle after single shot");
    end
  endtask
  task automatic t_cont();
    int c0;
    int c1;
    wr(`SNR_OFS_RUN, 8'h03);
    rdChk(`SNR_OFS_RUN, 1, 24'h00_0003, "run mode readback");
    wr(`SNR_OFS_GO, 8'h03);
    c0 = startCnt[0];
    c1 = startCnt[1];
    feDone(0, 16'h4C21);
    chk(24'(startCnt[0] - c0), 24'h00_0001, "continuous restart");
    feDone(1, 16'h3D17);
    chk(24'(startCnt[1] - c1), 24'h00_0001, "continuous humidity restart");
    rdChk(`SNR_OFS_ACT, 1, 24'h00_0003, "both still measuring");
    rdChk(`SNR_OFS_TEMP, 3, expRes(16'h4C21), "continuous result");
    rdChk(`SNR_OFS_HUM, 3, expRes(16'h3D17), "continuous humidity result");
    wr(`SNR_OFS_HALT, 8'h01);
    rdChk(`SNR_OFS_ACT, 1, 24'h00_0002, "temperature halted only");
    wr(`SNR_OFS_HALT, 8'h02);
    rdChk(`SNR_OFS_ACT, 1, 24'h00_0000, "humidity halted");
    feDone(1, 16'h0BAD);
    rdChk(`SNR_OFS_HUM, 3, expRes(16'h3D17), "completion after halt ignored");
    rdChk(`SNR_OFS_HALT, 1, 24'h00_0000, "halt register reads zero");
    wr(`SNR_OFS_RUN, 8'h00);
  endtask
  // Upper two bytes read alone must come from the copy held at the last first-byte read
  task automatic t_freeze();
    snr_result_t old;
    old = expRes(16'h4C21);
    wr(`SNR_OFS_GO, 8'h01);
    feDone(0, 16'h7E81);
    rdChk(`SNR_OFS_TEMP + 8'h01, 2, {8'h00, old[23:8]}, "held copy");
    rdChk(`SNR_OFS_TEMP, 3, expRes(16'h7E81), "fresh copy");
  endtask
  // Reset in mid-run, link idle, clears activity and the humidity readout
  task automatic t_midReset();
    wr(`SNR_OFS_GO, 8'h02);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    rdChk(`SNR_OFS_ACT, 1, 24'h00_0000, "activity after mid-run reset");
    rdChk(`SNR_OFS_HUM, 3, 24'h00_0000, "humidity readout after mid-run reset");
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Watchdog so a hung link still reaches the report
  initial
  begin
    repeat (90000) @(posedge clk);
    n_errors++;
    $display("MISMATCH at %0t: run did not finish", $time);
    finish_test();
  end
  initial
  begin
    rst_b = 1'b0;
    tempDone = 1'b0;
    humDone = 1'b0;
    tempData = 16'h0000;
    humData = 16'h0000;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    t_reset();
    t_single();
    t_cont();
    t_freeze();
    t_midReset();
    finish_test();
  end
endmodule
